// >>> hw/hps_defines.vh
// constants of the parallel host port: host-side map, processor-side map, field positions, reset values
// Function
// [R1] host reads receive bytes only when full
// [R2] host writes transmit bytes only when empty
// [R3] transmit bytes move whole into receive word
// [R4] device drives all outgoing status bits itself
// [R5] status held stable during a host access
// [R6] host reads encoded flag pair twice
// [R7] host changes vector only with command clear
// [R8] cleared command may still be taken
// [R9] host never clears command and changes vector
// [R10] host-set bits synchronised bit by bit
`ifndef HPS_DEFINES_VH
`define HPS_DEFINES_VH

// host-side register addresses on the three address pins
`define HPS_HA_CTRL      3'h0
`define HPS_HA_CMD       3'h1
`define HPS_HA_STAT      3'h2
`define HPS_HA_FLAGS     3'h3
`define HPS_HA_HIGH      3'h5
`define HPS_HA_MID       3'h6
`define HPS_HA_LOW       3'h7

// host control byte
`define HPS_HC_RXREQ     0
`define HPS_HC_TXREQ     1
// host command byte
`define HPS_CMD_BIT      7
`define HPS_CMD_VEC_HI   4
`define HPS_CMD_VEC_LO   0
// host flags byte
`define HPS_HF_LOWER     0
`define HPS_HF_UPPER     1
`define HPS_HF_DMA       2

// processor-side Wishbone byte offsets
`define HPS_WB_STAT      8'h00
`define HPS_WB_CTRL      8'h04
`define HPS_WB_RXWORD    8'h08
`define HPS_WB_TXWORD    8'h0C
`define HPS_WB_CMD       8'h10
`define HPS_WB_INTSTAT   8'h14
`define HPS_WB_INTMASK   8'h18

// processor control word
`define HPS_PC_FLAGLOW   0
`define HPS_PC_FLAGUP    1
`define HPS_PC_CMDEN     2
// processor command register: write one to take the command
`define HPS_PCMD_TAKE    0

// interrupt events
`define HPS_EV_RXWORD    0
`define HPS_EV_TXEMPTY   1
`define HPS_EV_CMD       2
`define HPS_EV_COUNT     3

`define HPS_BYTE_ZERO    8'h00
`define HPS_WORD_ZERO    32'h00000000
`define HPS_VEC_ZERO     5'h00
`define HPS_ADDR_ZERO    3'h0
`define HPS_RXWORD_ZERO  24'h000000
`define HPS_PIN_RESET    13'h1000

`endif

// >>> hw/hps_sync3.v
// three-stage synchroniser; each bit updates when its second and third stages agree
`timescale 1ns/1ps
module hps_sync3 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             mclk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      dout   <= INIT;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout   <= (agree & stage3) | (~agree & dout); // [R10]
    end
  end
endmodule // hps_sync3

// >>> hw/hps_irq.v
// sticky interrupt status with write-one-to-clear, mask and one level output
`timescale 1ns/1ps
module hps_irq #(
  parameter N = 3
) (
  input  wire         mclk,
  input  wire         rstn,
  input  wire [N-1:0] events,
  input  wire         clearWr,
  input  wire [N-1:0] clearBits,
  input  wire         maskWr,
  input  wire [N-1:0] maskData,
  output reg  [N-1:0] status,
  output reg  [N-1:0] mask,
  output reg          irq
);
  wire [N-1:0] cleared = clearWr ? (status & ~clearBits) : status;
  wire [N-1:0] next_status = cleared | events;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status <= {N{1'b0}};
      mask   <= {N{1'b0}};
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      if (maskWr)
        mask <= maskData;
      irq <= |(next_status & (maskWr ? maskData : mask));
    end
  end
endmodule // hps_irq

// >>> hw/hps_host_port.v
// parallel host port: asynchronous host pins on one side, Wishbone processor registers on the other
`timescale 1ns/1ps
`include "hps_defines.vh"
module hps_host_port (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        hostEnN,
  input  wire        hostRw,
  input  wire [2:0]  hostAddr,
  input  wire [7:0]  hostDataIn,
  output reg  [7:0]  hostDataOut,
  output reg         hostDataOeN,
  output reg         serviceRequestN,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        irq
);
  // byte-lane merge for processor reads
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer k;
    begin
      laneMerge = old;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          laneMerge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // a strobe qualified by a match on the host register address
  function hostHit;
    input       strobe;
    input [2:0] addr;
    input [2:0] want;
    begin
      hostHit = strobe & (addr == want);
    end
  endfunction

  // a strobe qualified by a match on the processor word offset
  function wbHit;
    input       strobe;
    input [7:0] offset;
    input [7:0] want;
    begin
      wbHit = strobe & (offset == want);
    end
  endfunction

  // every host pin bit passes its own three-stage chain
  wire [12:0] pinSync;
  hps_sync3 #(.WIDTH(13), .INIT(`HPS_PIN_RESET)) uPinSync (
    .mclk (mclk),
    .rstn (rstn),
    .din  ({hostEnN, hostRw, hostAddr, hostDataIn}),
    .dout (pinSync)
  ); // [R10]

  wire       enActive = ~pinSync[12];
  wire       syncRw   = pinSync[11];
  wire [2:0] syncAddr = pinSync[10:8];
  wire [7:0] syncData = pinSync[7:0];

  // host access tracking
  reg        accActive;
  reg        accRw;
  reg  [2:0] accAddr;
  reg  [7:0] accData;
  wire       accStart = enActive & ~accActive;
  wire       accEnd   = ~enActive & accActive;
  wire       hostWr   = accEnd & ~accRw;
  wire       hostRd   = accEnd & accRw;

  // host-side state
  reg  [7:0] rcvByteHigh;
  reg  [7:0] rcvByteMid;
  reg  [7:0] rcvByteLow;
  reg        receiveFullFlag;
  reg  [7:0] xmtByteHigh;
  reg  [7:0] xmtByteMid;
  reg  [7:0] xmtByteLow;
  reg        transmitEmptyFlag;
  reg        commandRequestBit;
  reg  [4:0] commandVectorField;
  reg        hostFlagLower;
  reg        hostFlagUpper;
  reg        dmaMode;
  reg        rxReqEn;
  reg        txReqEn;

  // processor-side state
  reg [23:0] dspSideReceiveWord;
  reg        dspReceiveFullFlag;
  reg        dspFlagLower;
  reg        dspFlagUpper;
  reg        commandEnable;
  reg        commandPendingFlag;
  reg        commandPendingLast;

  wire dspTransmitEmptyFlag = ~receiveFullFlag;
  wire transmitterReadyFlag = transmitEmptyFlag & ~dspReceiveFullFlag;
  wire requestActive = (receiveFullFlag & rxReqEn) | (transmitEmptyFlag & txReqEn);

  // Wishbone decode
  wire       wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wbWr  = wbReq & wb_we_i;
  wire       wbRd  = wbReq & ~wb_we_i;
  wire [7:0] wbOff = {wb_adr_i[7:2], 2'b00};

  wire wrCtrl    = wbHit(wbWr, wbOff, `HPS_WB_CTRL);
  wire wrTxWord  = wbHit(wbWr, wbOff, `HPS_WB_TXWORD);
  wire wrCmd     = wbHit(wbWr, wbOff, `HPS_WB_CMD);
  wire wrIntStat = wbHit(wbWr, wbOff, `HPS_WB_INTSTAT);
  wire wrIntMask = wbHit(wbWr, wbOff, `HPS_WB_INTMASK);
  wire rdRxWord  = wbHit(wbRd, wbOff, `HPS_WB_RXWORD);

  // transmit bytes move into the processor receive word once it is free
  wire moveWord = ~transmitEmptyFlag & ~dspReceiveFullFlag; // [R3]
  wire rxCleared = hostHit(hostRd, accAddr, `HPS_HA_LOW) & receiveFullFlag;

  wire [`HPS_EV_COUNT-1:0] irqStatus;
  wire [`HPS_EV_COUNT-1:0] irqMask;
  wire [`HPS_EV_COUNT-1:0] irqEvents;
  assign irqEvents[`HPS_EV_RXWORD]  = moveWord;
  assign irqEvents[`HPS_EV_TXEMPTY] = rxCleared;
  assign irqEvents[`HPS_EV_CMD]     = commandPendingFlag & ~commandPendingLast;

  hps_irq #(.N(`HPS_EV_COUNT)) uIrq (
    .mclk      (mclk),
    .rstn      (rstn),
    .events    (irqEvents),
    .clearWr   (wrIntStat & wb_sel_i[0]),
    .clearBits (wb_dat_i[`HPS_EV_COUNT-1:0]),
    .maskWr    (wrIntMask & wb_sel_i[0]),
    .maskData  (wb_dat_i[`HPS_EV_COUNT-1:0]),
    .status    (irqStatus),
    .mask      (irqMask),
    .irq       (irq)
  );

  // host read data, chosen from the address seen when the strobe was taken
  reg [7:0] hostReadMux;
  always @* begin
    case (syncAddr)
      `HPS_HA_CTRL:  hostReadMux = {6'h00, txReqEn, rxReqEn};
      `HPS_HA_CMD:   hostReadMux = {commandRequestBit, 2'h0, commandVectorField};
      `HPS_HA_STAT:  hostReadMux = {commandRequestBit, requestActive, dmaMode, dspFlagUpper, dspFlagLower,
                                   transmitterReadyFlag, transmitEmptyFlag, receiveFullFlag}; // [R4]
      `HPS_HA_FLAGS: hostReadMux = {5'h00, dmaMode, hostFlagUpper, hostFlagLower};
      `HPS_HA_HIGH:  hostReadMux = rcvByteHigh; // [R1]
      `HPS_HA_MID:   hostReadMux = rcvByteMid;
      `HPS_HA_LOW:   hostReadMux = rcvByteLow;
      default:       hostReadMux = `HPS_BYTE_ZERO;
    endcase
  end

  // host access: read data is captured once at the strobe and held to its end
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      accActive   <= 1'b0;
      accRw       <= 1'b1;
      accAddr     <= `HPS_ADDR_ZERO;
      accData     <= `HPS_BYTE_ZERO;
      hostDataOut <= `HPS_BYTE_ZERO;
      hostDataOeN <= 1'b1;
    end else begin
      accActive <= enActive;
      if (enActive) begin
        accRw   <= syncRw;
        accAddr <= syncAddr;
        accData <= syncData;
      end
      if (accStart) begin
        hostDataOut <= hostReadMux; // [R5]
        hostDataOeN <= ~syncRw;
      end else if (accEnd) begin
        hostDataOeN <= 1'b1;
      end
    end
  end

  // host-written registers, committed when the strobe is released
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      xmtByteHigh        <= `HPS_BYTE_ZERO;
      xmtByteMid         <= `HPS_BYTE_ZERO;
      xmtByteLow         <= `HPS_BYTE_ZERO;
      transmitEmptyFlag  <= 1'b1;
      commandRequestBit  <= 1'b0;
      commandVectorField <= `HPS_VEC_ZERO;
      hostFlagLower      <= 1'b0;
      hostFlagUpper      <= 1'b0;
      dmaMode            <= 1'b0;
      rxReqEn            <= 1'b0;
      txReqEn            <= 1'b0;
    end else begin
      // a full transmit word is not broken up by early host writes
      if (hostWr & transmitEmptyFlag) begin // [R2]
        case (accAddr)
          `HPS_HA_HIGH: xmtByteHigh <= accData;
          `HPS_HA_MID:  xmtByteMid  <= accData;
          `HPS_HA_LOW:  xmtByteLow  <= accData;
          default:      xmtByteLow  <= xmtByteLow;
        endcase
      end
      if (moveWord)
        transmitEmptyFlag <= 1'b1; // [R3]
      else if (hostHit(hostWr, accAddr, `HPS_HA_LOW) & transmitEmptyFlag)
        transmitEmptyFlag <= 1'b0;
      if (hostHit(hostWr, accAddr, `HPS_HA_CMD)) begin
        commandRequestBit  <= accData[`HPS_CMD_BIT]; // [R8]
        commandVectorField <= accData[`HPS_CMD_VEC_HI:`HPS_CMD_VEC_LO]; // [R7] [R9]
      end else if (wrCmd & wb_sel_i[0] & wb_dat_i[`HPS_PCMD_TAKE]) begin
        commandRequestBit <= 1'b0;
      end
      if (hostHit(hostWr, accAddr, `HPS_HA_FLAGS)) begin
        hostFlagLower <= accData[`HPS_HF_LOWER]; // [R6]
        hostFlagUpper <= accData[`HPS_HF_UPPER];
        dmaMode       <= accData[`HPS_HF_DMA];
      end
      if (hostHit(hostWr, accAddr, `HPS_HA_CTRL)) begin
        rxReqEn <= accData[`HPS_HC_RXREQ];
        txReqEn <= accData[`HPS_HC_TXREQ];
      end
    end
  end

  // data paths between the two sides and processor-driven flags
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rcvByteHigh        <= `HPS_BYTE_ZERO;
      rcvByteMid         <= `HPS_BYTE_ZERO;
      rcvByteLow         <= `HPS_BYTE_ZERO;
      receiveFullFlag    <= 1'b0;
      dspSideReceiveWord <= `HPS_RXWORD_ZERO;
      dspReceiveFullFlag <= 1'b0;
      dspFlagLower       <= 1'b0;
      dspFlagUpper       <= 1'b0;
      commandEnable      <= 1'b0;
      commandPendingFlag <= 1'b0;
      commandPendingLast <= 1'b0;
      serviceRequestN    <= 1'b1;
    end else begin
      if (moveWord) begin
        dspSideReceiveWord <= {xmtByteHigh, xmtByteMid, xmtByteLow}; // [R3]
        dspReceiveFullFlag <= 1'b1;
      end else if (rdRxWord) begin
        dspReceiveFullFlag <= 1'b0;
      end
      if (wrTxWord & dspTransmitEmptyFlag) begin
        rcvByteHigh     <= wb_sel_i[2] ? wb_dat_i[23:16] : rcvByteHigh;
        rcvByteMid      <= wb_sel_i[1] ? wb_dat_i[15:8]  : rcvByteMid;
        rcvByteLow      <= wb_sel_i[0] ? wb_dat_i[7:0]   : rcvByteLow;
        receiveFullFlag <= 1'b1; // [R4]
      end else if (rxCleared) begin
        receiveFullFlag <= 1'b0; // [R1]
      end
      if (wrCtrl & wb_sel_i[0]) begin
        dspFlagLower  <= wb_dat_i[`HPS_PC_FLAGLOW]; // [R4]
        dspFlagUpper  <= wb_dat_i[`HPS_PC_FLAGUP];
        commandEnable <= wb_dat_i[`HPS_PC_CMDEN];
      end
      // one register stage: a command withdrawn late may still be seen
      commandPendingFlag <= commandRequestBit & commandEnable; // [R8]
      commandPendingLast <= commandPendingFlag;
      serviceRequestN    <= ~requestActive; // [R4]
    end
  end

  // processor-side read mux
  reg [31:0] wbReadMux;
  always @* begin
    case (wbOff)
      `HPS_WB_STAT:    wbReadMux = {26'h0000000, dmaMode, hostFlagUpper, hostFlagLower,
                                    commandPendingFlag, dspTransmitEmptyFlag, dspReceiveFullFlag}; // [R10]
      `HPS_WB_CTRL:    wbReadMux = {29'h00000000, commandEnable, dspFlagUpper, dspFlagLower};
      `HPS_WB_RXWORD:  wbReadMux = {8'h00, dspSideReceiveWord};
      `HPS_WB_CMD:     wbReadMux = {27'h0000000, commandVectorField};
      `HPS_WB_INTSTAT: wbReadMux = {29'h00000000, irqStatus};
      `HPS_WB_INTMASK: wbReadMux = {29'h00000000, irqMask};
      default:         wbReadMux = `HPS_WORD_ZERO;
    endcase
  end

  // Wishbone answer one cycle after the request appears
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `HPS_WORD_ZERO;
    end else begin
      wb_ack_o <= wbReq;
      if (wbRd)
        wb_dat_o <= laneMerge(`HPS_WORD_ZERO, wbReadMux, wb_sel_i);
    end
  end
endmodule // hps_host_port

// >>> testbench/hps_host_port_asserts.sv
// concurrent checks on the host port pins and the Wishbone handshake
`timescale 1ns/1ps
module hps_host_port_asserts (
  input wire       mclk,
  input wire       rstn,
  input wire       hostEnN,
  input wire       hostRw,
  input wire [7:0] hostDataOut,
  input wire       hostDataOeN,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence wbReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence readStart;
    $fell(hostEnN) && hostRw && hostDataOeN;
  endsequence
  sequence strobeHeld;
    readStart ##1 (!hostEnN) [*4];
  endsequence
  ack_answer_a: assert property (wbReq |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  sync_delay_a: assert property (readStart |-> hostDataOeN [*2])
    else $error("strobe seen before synchroniser");
  read_answer_a: assert property (strobeHeld |-> ##[0:3] !hostDataOeN)
    else $error("read data not driven");
  data_stable_a: assert property (!hostDataOeN && $past(!hostDataOeN) |-> $stable(hostDataOut))
    else $error("read data changed in access");
  oe_release_a: assert property (hostEnN [*6] |-> hostDataOeN)
    else $error("data driven without strobe");
endmodule // hps_host_port_asserts
bind hps_host_port hps_host_port_asserts chk (.mclk(mclk), .rstn(rstn), .hostEnN(hostEnN), .hostRw(hostRw),
  .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// >>> testbench/hps_host_model.sv
// host microprocessor model on the asynchronous host pins
`timescale 1ns/1ps
module hps_host_model (
  input  wire        mclk,
  output logic       hostEnN,
  output logic       hostRw,
  output logic [2:0] hostAddr,
  output logic [7:0] hostDataIn,
  input  wire  [7:0] hostDataOut,
  input  wire        hostDataOeN,
  output logic       rdStb,
  output logic [7:0] rdData
);
  initial begin
    hostEnN = 1'b1;
    hostRw = 1'b1;
    hostAddr = 3'h0;
    hostDataIn = 8'h00;
    rdStb = 1'b0;
    rdData = 8'h00;
  end
  // strobe held well past the synchroniser so status is stable
  task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    hostRw <= ~w;
    hostAddr <= a;
    hostDataIn <= d;
    hostEnN <= 1'b0;
    repeat (8) @(posedge mclk);
    rdStb <= ~w;
    rdData <= hostDataOeN ? 8'hXX : hostDataOut;
    hostEnN <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    // hold time over: lines no longer carry the old value
    hostAddr <= ~a;
    hostDataIn <= ~d;
    repeat (3) @(posedge mclk);
  endtask
endmodule // hps_host_model

// >>> testbench/testbench.sv
// self-checking bench for the parallel host port
`timescale 1ns/1ps
`include "hps_defines.vh"
module testbench;
  logic        mclk, rstn, cyc, stb, we, ack, irq, srqN, enN, rw, oeN, rdStb;
  logic [2:0]  ha;
  logic [7:0]  hdi, hdo, rdData, adr, v;
  logic [31:0] dati, dato, w;
  logic [31:0] wbQ[$];
  logic [7:0]  hostQ[$];
  int          err_count, compares, cycles;
  hps_host_port dut (.mclk(mclk), .rstn(rstn), .hostEnN(enN), .hostRw(rw), .hostAddr(ha), .hostDataIn(hdi),
    .hostDataOut(hdo), .hostDataOeN(oeN), .serviceRequestN(srqN), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .irq(irq));
  hps_host_model hm (.mclk(mclk), .hostEnN(enN), .hostRw(rw), .hostAddr(ha), .hostDataIn(hdi),
    .hostDataOut(hdo), .hostDataOeN(oeN), .rdStb(rdStb), .rdData(rdData));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmpWb(input logic [31:0] e, input logic [31:0] g);
    chk("wishbone read", e, g);
  endtask
  task automatic cmpHost(input logic [7:0] e, input logic [7:0] g);
    chk("host read", {24'h000000, e}, {24'h000000, g});
  endtask
  task automatic cmpPin(input string n, input logic e, input logic g);
    chk(n, {31'h00000000, e}, {31'h00000000, g});
  endtask
  task automatic wrap_up();
    $display("counts: compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wbx(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dati <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdWb(input logic [7:0] a, input logic [31:0] e);
    wbQ.push_back(e);
    wbx(1'b0, a, 32'h00000000);
  endtask
  task automatic rdHost(input logic [2:0] a, input logic [7:0] e);
    hostQ.push_back(e);
    hm.access(1'b0, a, 8'h00);
  endtask
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0)
      cmpWb(wbQ.pop_front(), dato);
    if (rdStb === 1'b1)
      cmpHost(hostQ.pop_front(), rdData);
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    {rstn, cyc, stb, we, adr, dati} = '0;
    void'($urandom(32'h6F6C));
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rdWb(`HPS_WB_STAT, 32'h00000002);
    rdHost(`HPS_HA_STAT, 8'h06);
    $display("test reset done");
    w = $urandom & 32'h00FFFFFF;
    wbx(1'b1, `HPS_WB_INTMASK, 32'h00000001);
    hm.access(1'b1, `HPS_HA_HIGH, w[23:16]);
    hm.access(1'b1, `HPS_HA_MID, w[15:8]);
    hm.access(1'b1, `HPS_HA_LOW, w[7:0]);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge mclk);
    cmpPin("irq raised", 1'b1, irq);
    rdWb(`HPS_WB_STAT, 32'h00000003);
    rdWb(`HPS_WB_RXWORD, w);
    rdWb(`HPS_WB_INTSTAT, 32'h00000001);
    wbx(1'b1, `HPS_WB_INTMASK, 32'h00000000);
    @(posedge mclk);
    cmpPin("irq masked", 1'b0, irq);
    wbx(1'b1, `HPS_WB_INTSTAT, 32'h00000001);
    rdWb(`HPS_WB_INTSTAT, 32'h00000000);
    $display("test host to processor done");
    w = $urandom & 32'h00FFFFFF;
    wbx(1'b1, `HPS_WB_TXWORD, w);
    rdHost(`HPS_HA_STAT, 8'h07);
    rdHost(`HPS_HA_HIGH, w[23:16]);
    rdHost(`HPS_HA_MID, w[15:8]);
    rdHost(`HPS_HA_LOW, w[7:0]);
    rdHost(`HPS_HA_STAT, 8'h06);
    rdWb(`HPS_WB_INTSTAT, 32'h00000002);
    $display("test processor to host done");
    wbx(1'b1, `HPS_WB_CTRL, 32'h00000007);
    rdHost(`HPS_HA_STAT, 8'h1E);
    rdHost(`HPS_HA_STAT, 8'h1E);
    v = $urandom & 8'h1F;
    hm.access(1'b1, `HPS_HA_CMD, v);
    hm.access(1'b1, `HPS_HA_CMD, v | 8'h80);
    repeat (8) @(posedge mclk);
    rdWb(`HPS_WB_STAT, 32'h00000006);
    rdWb(`HPS_WB_CMD, {24'h000000, v});
    hm.access(1'b1, `HPS_HA_CMD, v);
    repeat (8) @(posedge mclk);
    rdWb(`HPS_WB_STAT, 32'h00000002);
    hm.access(1'b1, `HPS_HA_CMD, v | 8'h80);
    repeat (8) @(posedge mclk);
    wbx(1'b1, `HPS_WB_CMD, 32'h00000001);
    rdHost(`HPS_HA_CMD, v);
    rdWb(`HPS_WB_STAT, 32'h00000002);
    $display("test command done");
    v = $urandom & 8'h07;
    hm.access(1'b1, `HPS_HA_FLAGS, v);
    repeat (8) @(posedge mclk);
    rdWb(`HPS_WB_STAT, {26'h0, v[2:0], 3'h2});
    rdHost(`HPS_HA_FLAGS, v);
    hm.access(1'b1, `HPS_HA_CTRL, 8'h03);
    repeat (4) @(posedge mclk);
    cmpPin("service request", 1'b0, srqN);
    rdHost(`HPS_HA_CTRL, 8'h03);
    rdHost(`HPS_HA_STAT, 8'h5E | {v[2], 5'h00});
    hm.access(1'b1, `HPS_HA_CTRL, 8'h00);
    repeat (4) @(posedge mclk);
    cmpPin("service request", 1'b1, srqN);
    wbx(1'b1, 8'h1C, 32'hFFFFFFFF);
    rdWb(8'h1C, 32'h00000000);
    $display("test flags and unmapped done");
    wrap_up();
  end
endmodule // testbench
